// >>> logic/artc_top.sv
// Purpose: Control/status logic of an 8-bit auto-reload timer with prescaler
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes: Every access takes exactly one wait cycle
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "artc_consts.svh"

// What this block does
// R01: Ext select bit picks prescaler input clock
// R02: Prescaler divides input by two to select
// R03: Run bit clear freezes prescaler and counter
// R04: Force reload bit always reads as zero
// R05: Force reload loads counter, clears prescaler
// R06: Overflow request needs enable and flag set
// R07: Hardware sets flag; reading register clears it
// R08: Flag set when counter wraps FFh to reload
// R09: Overflow reloads counter, prescaler left alone
// R10: Reset clears counter, prescaler, selects CPU clock
// R11: Counter increments once per prescaler tick
// R12: Overflow during read keeps flag set
// R13: Control/status register resets to all zeros
module artc_top #(
  parameter int unsigned PRESC_BITS = `ARTC_PRESC_BITS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [`ARTC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // External count clock pin
  input wire logic ext_clk,
  // Timer state and interrupts
  output logic [7:0] counter_value,
  output logic overflow_irq_req,
  output logic irq
);

  // The tap field is three bits, so the prescaler must be seven
  if (PRESC_BITS != `ARTC_PRESC_BITS) begin : g_bad_width
    $error("prescaler width must match the three-bit tap field");
  end

  // Registers
  artc_pkg::artc_csr_t csr; // Control/status
  logic [7:0] reload_value_reg; // Auto-reload value
  logic [7:0] counter; // Timer counter
  logic [`ARTC_IRQ_BITS-1:0] irq_status; // Sticky events
  logic [`ARTC_IRQ_BITS-1:0] irq_mask; // Event enables
  logic ack; // Second cycle of an access
  logic rd_flag_seen; // Flag value handed to the reader
  artc_pkg::artc_req_t req; // Bus request bundle

  // Next values
  artc_pkg::artc_csr_t next_csr;
  logic [7:0] next_counter;
  logic [`ARTC_IRQ_BITS-1:0] next_irq_status;
  logic [31:0] next_readdata;

  // Address match, shared by all decodes
  function automatic logic artc_hit(input logic [`ARTC_ADDR_W-1:0] a,
                                    input logic [`ARTC_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // Bundle the bus inputs
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  // Handshake: one wait cycle, then accept
  wire req_active = req.read | req.write;
  wire accept = req_active & ack;
  wire capture = req_active & ~ack;
  wire wr_acc = req.write & accept & req.byteenable[0];
  wire rd_acc = req.read & accept;
  assign avs_waitrequest = req_active & ~ack;

  // Address decode
  wire hit_csr = artc_hit(req.address, `ARTC_OFS_CSR);
  wire hit_reload = artc_hit(req.address, `ARTC_OFS_RELOAD);
  wire hit_count = artc_hit(req.address, `ARTC_OFS_COUNT);
  wire hit_stat = artc_hit(req.address, `ARTC_OFS_IRQ_STAT);
  wire hit_mask = artc_hit(req.address, `ARTC_OFS_IRQ_MASK);

  // Write strobes; writes need byte lane 0, registers are at most 8 bits wide
  wire wr_csr = wr_acc & hit_csr;
  wire wr_reload = wr_acc & hit_reload;
  wire wr_stat = wr_acc & hit_stat;
  wire wr_mask = wr_acc & hit_mask;
  wire rd_csr = rd_acc & hit_csr;

  // Force reload is a pulse; it is never stored
  wire force_req = wr_csr & req.writedata[`ARTC_BIT_FORCE]; // R05

  // Prescaler input: CPU clock every cycle, or a synchronised pin edge
  logic ext_rise;
  artc_edge_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(ext_clk),
    .rise(ext_rise)
  );
  wire in_tick = csr.ext_clock_select ? ext_rise : 1'b1; // R01
  wire presc_en = csr.counter_run & in_tick; // R03

  // Prescaler; cleared by force reload, not by overflow
  logic [PRESC_BITS-1:0] presc_count;
  logic cnt_tick;
  artc_prescaler #(
    .PRESC_BITS(PRESC_BITS),
    .SEL_BITS(`ARTC_SEL_BITS)
  ) u_presc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(presc_en),
    .clear(force_req),
    .tap_sel(csr.prescale_select),
    .count(presc_count),
    .tick(cnt_tick)
  );

  // Counter wrap from FFh; a forced reload in the same cycle takes over
  wire at_max = counter == `ARTC_CNT_MAX;
  wire ovf_event = cnt_tick & at_max & ~force_req; // R08

  // Counter next value: force, then wrap, then increment
  assign next_counter = force_req ? reload_value_reg : // R05
                        ovf_event ? reload_value_reg : // R09
                        cnt_tick ? counter + 8'h01 : counter; // R11

  // Flag: set wins over the read-clear; only a reported flag is cleared
  wire flag_clear = rd_csr & rd_flag_seen; // R07
  wire next_flag = ovf_event | (csr.overflow_flag & ~flag_clear); // R07 R12

  // Control/status next value; the force bit is never held
  always_comb begin
    next_csr = csr;
    if (wr_csr) begin
      next_csr.ext_clock_select = req.writedata[`ARTC_BIT_EXT_SEL]; // R01
      next_csr.prescale_select = req.writedata[`ARTC_BIT_SEL_HI:`ARTC_BIT_SEL_LO]; // R02
      next_csr.counter_run = req.writedata[`ARTC_BIT_RUN]; // R03
      next_csr.overflow_irq_enable = req.writedata[`ARTC_BIT_OIE]; // R06
    end
    next_csr.force_reload = 1'b0; // R04
    next_csr.overflow_flag = next_flag;
  end

  // Sticky event bits, write one to clear; a new event wins
  wire [`ARTC_IRQ_BITS-1:0] events = {force_req, ovf_event};
  wire [`ARTC_IRQ_BITS-1:0] stat_clr =
    wr_stat ? req.writedata[`ARTC_IRQ_BITS-1:0] : `ARTC_IRQ_RESET;
  assign next_irq_status = (irq_status & ~stat_clr) | events;

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_readdata = `ARTC_BUS_ZERO;
    if (hit_csr) begin
      next_readdata[7:0] = csr;
      next_readdata[`ARTC_BIT_FORCE] = 1'b0; // R04
    end else if (hit_reload) begin
      next_readdata[7:0] = reload_value_reg;
    end else if (hit_count) begin
      next_readdata[7:0] = counter;
    end else if (hit_stat) begin
      next_readdata[`ARTC_IRQ_BITS-1:0] = irq_status;
    end else if (hit_mask) begin
      next_readdata[`ARTC_IRQ_BITS-1:0] = irq_mask;
    end
  end

  // Bus handshake and read data; data is taken in the wait cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      avs_readdata <= `ARTC_BUS_ZERO;
      rd_flag_seen <= 1'b0;
    end else begin
      ack <= capture;
      if (capture && req.read) begin
        avs_readdata <= next_readdata;
        rd_flag_seen <= csr.overflow_flag; // R12
      end
    end
  end

  // Control/status register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csr <= `ARTC_CSR_RESET; // R13 R10
    end else begin
      csr <= next_csr;
    end
  end

  // Counter and reload value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= `ARTC_CNT_CLEAR; // R10
      reload_value_reg <= `ARTC_RELOAD_RESET;
    end else begin
      counter <= next_counter;
      if (wr_reload) begin
        reload_value_reg <= req.writedata[7:0];
      end
    end
  end

  // Interrupt status and mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `ARTC_IRQ_RESET;
      irq_mask <= `ARTC_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= req.writedata[`ARTC_IRQ_BITS-1:0];
      end
    end
  end

  // Outputs, all from registers
  assign counter_value = counter;
  assign overflow_irq_req = csr.overflow_irq_enable & csr.overflow_flag; // R06
  assign irq = |(irq_status & irq_mask);

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A counter wrap in one cycle
  sequence wrap_s;
    cnt_tick && at_max && !force_req;
  endsequence

  // A control/status read that saw the flag, with no new wrap
  sequence seen_read_s;
    req.read && hit_csr && ack && rd_flag_seen && !ovf_event;
  endsequence

  // Count step with CPU clock and tap zero
  sequence cpu_step_s;
    csr.counter_run && !csr.ext_clock_select && csr.prescale_select == 3'h0
      && !at_max && !force_req;
  endsequence

  flag_on_wrap_a: assert property (wrap_s |=> csr.overflow_flag) // R08
    else $error("flag not set after wrap");
  wrap_reload_a: assert property (wrap_s |=> counter == $past(reload_value_reg)) // R09
    else $error("counter not reloaded on wrap");
  wrap_presc_kept_a: assert property (wrap_s |=> // R09
    presc_count == $past(presc_count) + PRESC_BITS'(1))
    else $error("prescaler disturbed by wrap");
  force_load_a: assert property (force_req |=> // R05
    counter == $past(reload_value_reg) && presc_count == '0)
    else $error("forced reload did not load counter");
  force_reads_zero_a: assert property (rd_csr |-> !avs_readdata[`ARTC_BIT_FORCE]) // R04
    else $error("force bit read as one");
  irq_gate_a: assert property (wrap_s && csr.overflow_irq_enable && !wr_csr |=> // R06
    overflow_irq_req)
    else $error("overflow request missing after wrap");
  read_clears_a: assert property (seen_read_s |=> !csr.overflow_flag) // R07
    else $error("flag not cleared by read");
  keep_on_read_a: assert property (rd_csr && ovf_event |=> csr.overflow_flag) // R12
    else $error("overflow lost during read");
  frozen_a: assert property (!csr.counter_run && !force_req |=> // R03
    $stable(counter) && $stable(presc_count)) else $error("counter moved while stopped");
  cpu_count_a: assert property (cpu_step_s |=> counter == $past(counter) + 8'h01) // R11 R01
    else $error("counter did not step on CPU clock");
  bus_answer_a: assert property ($rose(req_active) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  reset_zero_a: assert property ($rose(rst_n) |-> csr == `ARTC_CSR_RESET) // R13
    else $error("control/status not zero after reset");

endmodule

// >>> logic/artc_consts.svh
// Purpose: Constants of the auto-reload timer control block
// Assumes: Included by its bare name from artc_top and artc_prescaler
// Notes: Byte offsets on a 32-bit Avalon-MM slave, one word per register
`ifndef ARTC_CONSTS_SVH
`define ARTC_CONSTS_SVH

// Register byte offsets
`define ARTC_ADDR_W 5
`define ARTC_OFS_CSR 5'h00
`define ARTC_OFS_RELOAD 5'h04
`define ARTC_OFS_COUNT 5'h08
`define ARTC_OFS_IRQ_STAT 5'h0C
`define ARTC_OFS_IRQ_MASK 5'h10

// Control/status field positions
`define ARTC_BIT_EXT_SEL 7
`define ARTC_BIT_SEL_HI 6
`define ARTC_BIT_SEL_LO 4
`define ARTC_BIT_RUN 3
`define ARTC_BIT_FORCE 2
`define ARTC_BIT_OIE 1
`define ARTC_BIT_FLAG 0

// Reset values and counter limits
`define ARTC_CSR_RESET 8'h00
`define ARTC_RELOAD_RESET 8'h00
`define ARTC_CNT_CLEAR 8'h00
`define ARTC_CNT_MAX 8'hFF
`define ARTC_IRQ_RESET 2'h0
`define ARTC_BUS_ZERO 32'h0000_0000

// Interrupt status bits
`define ARTC_IRQ_BITS 2
`define ARTC_EV_OVF 0
`define ARTC_EV_FORCE 1

// Prescaler geometry
`define ARTC_PRESC_BITS 7
`define ARTC_SEL_BITS 3

`endif

// >>> logic/artc_pkg.sv
// Purpose: Types shared by the auto-reload timer control block
// Assumes: Field layout matches artc_consts.svh
// Notes: Types only; constants live in the header
package artc_pkg;

  // Control/status register, bit 7 down to bit 0
  typedef struct packed {
    logic ext_clock_select;
    logic [2:0] prescale_select;
    logic counter_run;
    logic force_reload;
    logic overflow_irq_enable;
    logic overflow_flag;
  } artc_csr_t;

  // One Avalon-MM request as seen by the slave
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } artc_req_t;

endpackage

// >>> logic/artc_edge_sync.sv
// Purpose: Synchronise the external count clock pin and find rising edges
// Assumes: Pin is slower than half of ref_clk
// Notes: First flop is read only by the second
`timescale 1ns/100ps
module artc_edge_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin in, edge out
  input wire logic pin_in,
  output logic rise
);

  logic meta; // First stage, may go metastable
  logic stable; // Second stage, safe to use
  logic last; // Previous stable level

  // Two-flop synchroniser plus history flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_in;
      stable <= meta;
      last <= stable;
    end
  end

  // One-cycle pulse per rising edge of the pin
  assign rise = stable & ~last;

  // A rise never lasts two cycles
  edge_single_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R01
    rise |=> !rise) else $error("external edge pulse longer than one cycle");

endmodule

// >>> logic/artc_prescaler.sv
// Purpose: Binary prescaler with selectable power-of-two tap
// Assumes: Enable already folds in the run bit and the input clock choice
// Notes: Clear wins over enable, so a forced reload starts from zero
`timescale 1ns/100ps
`include "artc_consts.svh"
module artc_prescaler #(
  parameter int unsigned PRESC_BITS = `ARTC_PRESC_BITS,
  parameter int unsigned SEL_BITS = `ARTC_SEL_BITS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic clear,
  input wire logic [SEL_BITS-1:0] tap_sel,
  // Status
  output logic [PRESC_BITS-1:0] count,
  output logic tick
);

  // Every tap code must name a real counter bit
  if (PRESC_BITS != (1 << SEL_BITS) - 1) begin : g_bad_geometry
    $error("prescaler width does not match tap select width");
  end

  logic [PRESC_BITS-1:0] tap_mask; // Low bits that must all be one
  logic [PRESC_BITS-1:0] next_count;

  // Division by 2^n: tick when the low n bits are all ones
  assign tap_mask = PRESC_BITS'((PRESC_BITS+1)'(1) << tap_sel) - PRESC_BITS'(1); // R02
  assign tick = enable & ~clear & ((count & tap_mask) == tap_mask); // R02
  assign next_count = clear ? '0 : (enable ? count + PRESC_BITS'(1) : count); // R03 R05

  // Counter register; cleared at reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0; // R10
    end else begin
      count <= next_count;
    end
  end

  // Tick only when the selected tap wraps
  tap_tick_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R02
    tick |-> enable && ((count & tap_mask) == tap_mask))
    else $error("prescaler tick without tap wrap");

endmodule

// >>> verif/test_auto_reload_timer_control.sv
// Purpose: Self-checking bench for the auto-reload timer control block
// Assumes: One wait cycle per Avalon-MM access, as the design hand-over states
// Notes: Waitrequest and read data are taken at the rising edge, ahead of its updates
`timescale 1ns/100ps
`include "artc_consts.svh"
module test_auto_reload_timer_control;
  // Clock, reset and bus drive
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic ext_clk = 1'b0;
  // Design outputs
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] counter_value;
  logic overflow_irq_req;
  logic irq;
  // Bookkeeping
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [7:0] c0;
  int k;

  artc_top DUT (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_clk(ext_clk), .counter_value(counter_value),
    .overflow_irq_req(overflow_irq_req), .irq(irq)
  );

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Watchdog: a hung handshake must still reach the verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish in time", $time);
      finish_test();
    end
  end

  // Single place where values are compared
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One bus access; request held until waitrequest is low at a rising edge
  task automatic bus_op(input logic rd, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] rq);
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Sampled at the edge, before that edge's own updates land
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    bus_op(1'b0, a, {24'h00_0000, d}, 4'hF, dummy);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] rq;
    bus_op(1'b1, a, 32'h0000_0000, 4'hF, rq);
    check_val(rq, {24'h00_0000, e});
  endtask

  // Outputs checked mid-cycle so the last edge has landed
  task automatic out_chk(input logic [7:0] cnt, input logic req, input logic ir);
    @(negedge ref_clk);
    check_val({24'h00_0000, counter_value}, {24'h00_0000, cnt});
    check_val({31'h0000_0000, overflow_irq_req}, {31'h0000_0000, req});
    check_val({31'h0000_0000, irq}, {31'h0000_0000, ir});
  endtask

  // Prints the counts and the verdict, then closes the run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset state of registers and outputs
    out_chk(8'h00, 1'b0, 1'b0);
    rd_chk(`ARTC_OFS_CSR, 8'h00);
    rd_chk(`ARTC_OFS_RELOAD, 8'h00);
    rd_chk(`ARTC_OFS_IRQ_MASK, 8'h00);
    // Force bit reads back as zero; stopped counter is not loaded off zero
    wr(`ARTC_OFS_CSR, 8'h74);
    rd_chk(`ARTC_OFS_CSR, 8'h70);
    // Byte lane 0 disabled: write refused
    bus_op(1'b0, `ARTC_OFS_CSR, 32'h0000_0008, 4'hE, q);
    rd_chk(`ARTC_OFS_CSR, 8'h70);
    // Unmapped place reads zero and swallows writes
    wr(5'h14, 8'hA5);
    rd_chk(5'h14, 8'h00);
    // Every tap: 16 counter steps take exactly 16 << n cycles
    for (k = 0; k < 8; k++) begin
      wr(`ARTC_OFS_CSR, {1'b0, k[2:0], 4'b1000});
      repeat (2) @(negedge ref_clk);
      c0 = counter_value;
      repeat (16 << k) @(negedge ref_clk);
      check_val({24'h00_0000, counter_value - c0}, 32'h0000_0010);
    end
    // Run bit cleared: counter holds
    wr(`ARTC_OFS_CSR, 8'h00);
    @(negedge ref_clk);
    c0 = counter_value;
    repeat (40) @(posedge ref_clk);
    out_chk(c0, 1'b0, 1'b0);
    rd_chk(`ARTC_OFS_COUNT, c0);
    // External input, tap 0: pin idle means no counting, ten rises mean ten steps
    wr(`ARTC_OFS_CSR, 8'h88);
    repeat (40) @(posedge ref_clk);
    out_chk(c0, 1'b0, 1'b0);
    repeat (10) begin
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    out_chk(c0 + 8'h0A, 1'b0, 1'b0);
    // Stop, clear flag and event bits left from the runs above
    wr(`ARTC_OFS_CSR, 8'h00);
    bus_op(1'b1, `ARTC_OFS_CSR, 32'h0000_0000, 4'hF, q);
    wr(`ARTC_OFS_IRQ_STAT, 8'h03);
    // Forced reload works while stopped
    wr(`ARTC_OFS_RELOAD, 8'h80);
    wr(`ARTC_OFS_CSR, 8'h04);
    out_chk(8'h80, 1'b0, 1'b0);
    rd_chk(`ARTC_OFS_CSR, 8'h00);
    // Run with interrupt enabled until the wrap
    wr(`ARTC_OFS_CSR, 8'h0A);
    k = 0;
    while (overflow_irq_req !== 1'b1 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    check_val({24'h00_0000, counter_value}, 32'h0000_0080);
    wr(`ARTC_OFS_CSR, 8'h02);
    @(negedge ref_clk);
    check_val({31'h0000_0000, overflow_irq_req}, 32'h0000_0001);
    // Read returns the flag and clears it
    rd_chk(`ARTC_OFS_CSR, 8'h03);
    @(negedge ref_clk);
    check_val({31'h0000_0000, overflow_irq_req}, 32'h0000_0000);
    rd_chk(`ARTC_OFS_CSR, 8'h02);
    // Enable off: flag sets, no request
    wr(`ARTC_OFS_CSR, 8'h08);
    repeat (300) @(negedge ref_clk);
    check_val({31'h0000_0000, overflow_irq_req}, 32'h0000_0000);
    wr(`ARTC_OFS_CSR, 8'h00);
    rd_chk(`ARTC_OFS_CSR, 8'h01);
    // Status bits: overflow and forced reload both seen, masked
    rd_chk(`ARTC_OFS_IRQ_STAT, 8'h03);
    @(negedge ref_clk);
    check_val({31'h0000_0000, irq}, 32'h0000_0000);
    wr(`ARTC_OFS_IRQ_MASK, 8'h01);
    @(negedge ref_clk);
    check_val({31'h0000_0000, irq}, 32'h0000_0001);
    wr(`ARTC_OFS_IRQ_STAT, 8'h01);
    @(negedge ref_clk);
    check_val({31'h0000_0000, irq}, 32'h0000_0000);
    rd_chk(`ARTC_OFS_IRQ_STAT, 8'h02);
    wr(`ARTC_OFS_IRQ_MASK, 8'h03);
    @(negedge ref_clk);
    check_val({31'h0000_0000, irq}, 32'h0000_0001);
    wr(`ARTC_OFS_IRQ_STAT, 8'h02);
    @(negedge ref_clk);
    check_val({31'h0000_0000, irq}, 32'h0000_0000);
    rd_chk(`ARTC_OFS_IRQ_MASK, 8'h03);
    // Wrap lands on the accept edge of a read: the reader sees no flag, flag stays
    wr(`ARTC_OFS_RELOAD, 8'hFD);
    wr(`ARTC_OFS_CSR, 8'h04);
    wr(`ARTC_OFS_CSR, 8'h08);
    rd_chk(`ARTC_OFS_CSR, 8'h08);
    wr(`ARTC_OFS_CSR, 8'h00);
    rd_chk(`ARTC_OFS_CSR, 8'h01);
    // Counter register is read-only; known value from a forced reload
    wr(`ARTC_OFS_RELOAD, 8'h5A);
    wr(`ARTC_OFS_CSR, 8'h04);
    wr(`ARTC_OFS_COUNT, 8'h11);
    rd_chk(`ARTC_OFS_COUNT, 8'h5A);
    finish_test();
  end
endmodule
